// ---- pcs_checker_assertions.sv ----
// concurrent checks on the program counter and call stack ports
`timescale 1ns/1ps
`default_nettype none
module pcs_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // sequencing requests
    input wire logic        advance,
    input wire logic        low_byte_write,
    input wire logic [7:0]  low_byte_data,
    input wire logic        direct_call,
    input wire logic [10:0] call_operand,
    input wire logic        computed_subroutine_jump,
    input wire logic        branch_by_accumulator,
    input wire logic        branch_by_literal,
    input wire logic [8:0]  branch_offset,
    input wire logic        interrupt_vector,
    input wire logic [14:0] vector_address,
    input wire logic        return_any,
    input wire logic        latch_write,
    input wire logic [6:0]  latch_data,
    input wire logic [7:0]  accumulator,
    // results
    input wire logic [14:0] program_counter,
    input wire logic        stack_fault_reset
);
    // shadow of the high latch; only valid while software leaves the axi copy alone
    logic [6:0]  latch_r;
    wire         push      = direct_call | computed_subroutine_jump | interrupt_vector;
    wire         above_br  = push | return_any;
    wire         above_lbw = above_br | branch_by_accumulator | branch_by_literal;
    wire [14:0]  bo_ext    = {{6{branch_offset[8]}}, branch_offset};
    always @(posedge clk or posedge reset) begin
        if (reset) latch_r <= 7'h00;
        else if (latch_write) latch_r <= latch_data;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ============================================================
    // assertions
    a_reset_pc_clear: assert property (disable iff (1'b0)
        reset |-> program_counter == 15'h0) else $error("pc not cleared in reset");
    a_advance_step: assert property (
        advance && !above_lbw && !low_byte_write |=> program_counter == $past(program_counter) + 15'h1)
        else $error("advance did not step pc");
    a_low_write_load: assert property (
        low_byte_write && !above_lbw |=> program_counter == {$past(latch_r), $past(low_byte_data)})
        else $error("low byte write target wrong");
    a_direct_call_target: assert property (
        direct_call |=> program_counter[10:0] == $past(call_operand)
        && {3'h0, program_counter[14:11]} == ($past(latch_r) >> 3)) else $error("call target wrong");
    a_computed_call_target: assert property (
        computed_subroutine_jump && !direct_call |=> program_counter == {$past(latch_r), $past(accumulator)})
        else $error("computed call target wrong");
    a_acc_branch_sum: assert property (
        branch_by_accumulator && !above_br
        |=> program_counter == $past(program_counter) + 15'h1 + {7'h0, $past(accumulator)})
        else $error("accumulator branch target wrong");
    a_lit_branch_sum: assert property (
        branch_by_literal && !above_br && !branch_by_accumulator
        |=> program_counter == $past(program_counter) + 15'h1 + $past(bo_ext)) else $error("literal branch wrong");
    a_vector_target: assert property (
        interrupt_vector && !direct_call && !computed_subroutine_jump
        |=> program_counter == $past(vector_address)) else $error("vector target wrong");
    a_call_return_pair: assert property (
        push ##1 (return_any && !push) |=> program_counter == $past(program_counter, 2) + 15'h1)
        else $error("return address wrong");
    a_fault_pulse_single: assert property (
        stack_fault_reset |=> !stack_fault_reset) else $error("fault reset longer than one cycle");
    c_call_return: cover property (push ##1 return_any);
    c_fault: cover property (stack_fault_reset);
    c_back_branch: cover property (branch_by_literal && branch_offset[8]);
endmodule
bind pcs_core pcs_checker u_chk (.*);
`default_nettype wire

// ---- pcs_core.v ----
// program counter sequencing and return-address stack with an axi4-lite register slave
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.vh"

module pcs_core (
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // sequencing requests from decoder and interrupt logic, one-cycle pulses
    input  wire        advance,
    input  wire        low_byte_write,
    input  wire [7:0]  low_byte_data,
    input  wire        direct_call,
    input  wire [10:0] call_operand,
    input  wire        computed_subroutine_jump,
    input  wire        branch_by_accumulator,
    input  wire        branch_by_literal,
    input  wire [8:0]  branch_offset,
    input  wire        interrupt_vector,
    input  wire [14:0] vector_address,
    input  wire        return_any,
    input  wire        latch_write,
    input  wire [6:0]  latch_data,
    input  wire [7:0]  accumulator,
    // counter and fault outputs
    output reg  [14:0] program_counter,
    output reg         stack_fault_reset,
    output wire        irq,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // ============================================================
    // state
    reg [14:0] stack_mem [0:`PCS_DEPTH-1];
    reg [6:0]  counter_high_latch_r;
    reg [4:0]  stack_pointer_r;
    reg        stack_fault_reset_enable_r;
    reg [1:0]  status_r;
    reg [1:0]  mask_r;
    reg [7:0]  aw_addr_r;
    reg        aw_have_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;
    reg        w_have_r;

    // ============================================================
    // sequencing arithmetic
    wire [14:0] pc_inc   = program_counter + 15'h0001;
    wire [14:0] br_acc   = pc_inc + {7'h00, accumulator};
    wire [14:0] br_lit   = pc_inc + {{6{branch_offset[8]}}, branch_offset};
    wire        push     = direct_call | computed_subroutine_jump | interrupt_vector;
    wire        pop      = return_any;
    wire [4:0]  sp_push  = stack_pointer_r + 5'h01;
    wire [4:0]  sp_pop   = stack_pointer_r - 5'h01;
    wire [3:0]  push_idx = sp_push[3:0];
    wire [3:0]  top_idx  = stack_pointer_r[3:0];
    wire [14:0] top_val  = stack_mem[top_idx];
    // overflow when pointer already at the last level, underflow when below the first
    wire        ovf_ev   = push & (stack_pointer_r == `PCS_SP_TOP);
    wire        unf_ev   = pop  & (stack_pointer_r == `PCS_SP_RESET);

    // ============================================================
    // axi write path: address and data taken in either order
    assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have_r  & ~s_axi_bvalid;
    wire   wr_go  = aw_have_r & w_have_r & ~s_axi_bvalid;
    wire   wr_low = wr_go & w_strb_r[0];
    wire   wr_sel_low   = wr_low & (aw_addr_r == `PCS_OFS_CNT_LOW);
    wire   wr_sel_latch = wr_low & (aw_addr_r == `PCS_OFS_HIGH_LATCH);
    wire   wr_sel_sp    = wr_low & (aw_addr_r == `PCS_OFS_STACK_PTR);
    wire   wr_sel_tl    = wr_low & (aw_addr_r == `PCS_OFS_TOP_LOW);
    wire   wr_sel_th    = wr_low & (aw_addr_r == `PCS_OFS_TOP_HIGH);
    wire   wr_sel_mask  = wr_low & (aw_addr_r == `PCS_OFS_MASK);
    wire   wr_sel_cfg   = wr_low & (aw_addr_r == `PCS_OFS_CONFIG);
    reg    wr_known;
    always @* begin
        case (aw_addr_r)
            `PCS_OFS_CNT_LOW, `PCS_OFS_HIGH_LATCH, `PCS_OFS_STACK_PTR, `PCS_OFS_TOP_LOW,
            `PCS_OFS_TOP_HIGH, `PCS_OFS_STATUS, `PCS_OFS_MASK, `PCS_OFS_CONFIG,
            `PCS_OFS_COUNTER: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            aw_have_r    <= 1'b0;
            aw_addr_r    <= 8'h00;
            w_have_r     <= 1'b0;
            w_data_r     <= 32'h00000000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PCS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ============================================================
    // axi read path; reading status clears it on the accepting edge
    assign s_axi_arready = ~s_axi_rvalid;
    wire   rd_go   = s_axi_arvalid & s_axi_arready;
    wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
    wire   rd_stat = rd_go & (rd_addr == `PCS_OFS_STATUS);
    reg [31:0] rd_val;
    reg        rd_ok;
    always @* begin
        rd_ok  = 1'b1;
        rd_val = 32'h00000000;
        case (rd_addr)
            `PCS_OFS_CNT_LOW:    rd_val = {24'h000000, program_counter[7:0]};
            `PCS_OFS_HIGH_LATCH: rd_val = {25'h0000000, counter_high_latch_r};
            `PCS_OFS_STACK_PTR:  rd_val = {27'h0000000, stack_pointer_r};
            `PCS_OFS_TOP_LOW:    rd_val = {24'h000000, top_val[7:0]};
            `PCS_OFS_TOP_HIGH:   rd_val = {25'h0000000, top_val[14:8]};
            `PCS_OFS_STATUS:     rd_val = {30'h00000000, status_r};
            `PCS_OFS_MASK:       rd_val = {30'h00000000, mask_r};
            `PCS_OFS_CONFIG:     rd_val = {31'h00000000, stack_fault_reset_enable_r};
            `PCS_OFS_COUNTER:    rd_val = {17'h00000, program_counter};
            default:             rd_ok  = 1'b0;
        endcase
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `PCS_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ============================================================
    // status, mask, config; a new event beats the read-clear in the same cycle
    wire [1:0] ev = {unf_ev, ovf_ev};
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            status_r                   <= 2'h0;
            mask_r                     <= 2'h0;
            stack_fault_reset_enable_r <= 1'b0;
        end else begin
            status_r <= (rd_stat ? 2'h0 : status_r) | ev;
            if (wr_sel_mask)
                mask_r <= w_data_r[1:0];
            if (wr_sel_cfg)
                stack_fault_reset_enable_r <= w_data_r[`PCS_CFG_FAULT_BIT];
        end
    end
    assign irq = |(status_r & mask_r);

    // fault reset request, one-cycle pulse toward the reset controller
    always @(posedge clk or posedge reset) begin
        if (reset)
            stack_fault_reset <= 1'b0;
        else
            stack_fault_reset <= stack_fault_reset_enable_r & (ovf_ev | unf_ev);
    end

    // ============================================================
    // high latch: written only by software or decoder, never by stack traffic
    always @(posedge clk or posedge reset) begin
        if (reset)
            counter_high_latch_r <= 7'h00;
        else if (latch_write)
            counter_high_latch_r <= latch_data;
        else if (wr_sel_latch)
            counter_high_latch_r <= w_data_r[6:0];
    end

    // ============================================================
    // program counter; decoder requests are mutually exclusive by construction
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            program_counter <= 15'h0000;
        end else if (direct_call) begin
            program_counter <= {counter_high_latch_r[6:3], call_operand};
        end else if (computed_subroutine_jump) begin
            program_counter <= {counter_high_latch_r, accumulator};
        end else if (interrupt_vector) begin
            program_counter <= vector_address;
        end else if (pop) begin
            program_counter <= top_val;
        end else if (branch_by_accumulator) begin
            program_counter <= br_acc;
        end else if (branch_by_literal) begin
            program_counter <= br_lit;
        end else if (low_byte_write) begin
            program_counter <= {counter_high_latch_r, low_byte_data};
        end else if (wr_sel_low) begin
            program_counter <= {counter_high_latch_r, w_data_r[7:0]};
        end else if (advance) begin
            program_counter <= pc_inc;
        end
    end

    // ============================================================
    // stack pointer and storage; push stores the return address (next instruction)
    always @(posedge clk or posedge reset) begin
        if (reset)
            stack_pointer_r <= `PCS_SP_RESET;
        else if (push)
            stack_pointer_r <= ovf_ev ? 5'h10 : {1'b0, push_idx};
        else if (pop)
            stack_pointer_r <= unf_ev ? 5'h0F : sp_pop;
        else if (wr_sel_sp)
            stack_pointer_r <= w_data_r[4:0];
    end

    // storage is not reset, like the real array; it is written only at the selected entry
    genvar gi;
    generate
        for (gi = 0; gi < `PCS_DEPTH; gi = gi + 1) begin : g_ent
            always @(posedge clk) begin
                if (push && push_idx == gi)
                    stack_mem[gi] <= pc_inc;
                else if (!push && !pop && wr_sel_tl && top_idx == gi)
                    stack_mem[gi][7:0] <= w_data_r[7:0];
                else if (!push && !pop && wr_sel_th && top_idx == gi)
                    stack_mem[gi][14:8] <= w_data_r[6:0];
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ---- pcs_decoder_model.sv ----
// behavioural decoder and interrupt source: one sequencing pulse per command code
`timescale 1ns/1ps
`default_nettype none
module pcs_decoder_model (
    // command, at most one per cycle
    input  wire logic [3:0] cmd,
    // sequencing pulses
    output logic            advance,
    output logic            low_byte_write,
    output logic            direct_call,
    output logic            computed_subroutine_jump,
    output logic            branch_by_accumulator,
    output logic            branch_by_literal,
    output logic            interrupt_vector,
    output logic            return_any,
    output logic            latch_write
);
    // one-hot decode, so a push and a pop never share a cycle
    assign advance = cmd == 4'h1, low_byte_write = cmd == 4'h2, direct_call = cmd == 4'h3;
    assign computed_subroutine_jump = cmd == 4'h4, branch_by_accumulator = cmd == 4'h5;
    assign branch_by_literal = cmd == 4'h6, interrupt_vector = cmd == 4'h7;
    assign return_any = cmd == 4'h8, latch_write = cmd == 4'h9;
endmodule
`default_nettype wire

// ---- pcs_regs.vh ----
// register map, field positions and reset values of the program counter and call stack
//
// Function
// - 15-bit counter; low byte readable/writable, upper seven bits load only via latch.
// - Every reset clears the whole program counter to zero.
// - Writing the low byte loads upper bits from the high latch together.
// - Direct call: low byte and bits 10..8 from operand, 14..11 from latch.
// - Computed call: low byte from accumulator, upper seven bits from latch.
// - Accumulator branch: counter becomes incremented counter plus unsigned accumulator.
// - Literal branch: incremented counter plus sign-extended 9-bit offset.
// - Return stack of 16 entries of 15 bits, outside program and data space.
// - Push on calls and interrupt vectoring; pop on the three return kinds.
// - Push and pop leave the high latch unchanged.
// - Fault reset disabled: stack is circular, seventeenth push overwrites the first.
// - Overflow and underflow flags set regardless of fault reset enable.
// - Fault reset enabled: overflow or underflow requests a device reset, flag set.
// - 5-bit stack pointer readable at any time, covering overflow and underflow.
// - Top-of-stack high/low pair reads and writes entry selected by pointer.
// - Push: increment pointer then store; return: read entry then decrement.
`ifndef PCS_REGS_VH
`define PCS_REGS_VH

// ============================================================
// register byte offsets
`define PCS_OFS_CNT_LOW     8'h00
`define PCS_OFS_HIGH_LATCH  8'h04
`define PCS_OFS_STACK_PTR   8'h08
`define PCS_OFS_TOP_LOW     8'h0C
`define PCS_OFS_TOP_HIGH    8'h10
`define PCS_OFS_STATUS      8'h14
`define PCS_OFS_MASK        8'h18
`define PCS_OFS_CONFIG      8'h1C
`define PCS_OFS_COUNTER     8'h20

// ============================================================
// field positions and widths
`define PCS_PC_W            15
`define PCS_SP_W            5
`define PCS_DEPTH           16
`define PCS_ST_OVF_BIT      0
`define PCS_ST_UNF_BIT      1
`define PCS_CFG_FAULT_BIT   0

// ============================================================
// reset values; pointer rests one below level zero so the first push lands on entry 0
`define PCS_SP_RESET        5'h1F
`define PCS_SP_TOP          5'h0F

// ============================================================
// axi responses
`define PCS_RESP_OKAY       2'h0
`define PCS_RESP_SLVERR     2'h2

`endif

// ---- tb_top.sv ----
// self-checking bench for the program counter and call stack
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk, reset, advance, low_byte_write, direct_call, computed_subroutine_jump;
    logic        branch_by_accumulator, branch_by_literal, interrupt_vector, return_any;
    logic        latch_write, stack_fault_reset, irq, fault_seen, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [3:0]  cmd, s_axi_wstrb;
    logic [6:0]  latch_data;
    logic [7:0]  low_byte_data, accumulator, s_axi_awaddr, s_axi_araddr;
    logic [8:0]  branch_offset;
    logic [10:0] call_operand;
    logic [14:0] program_counter, vector_address;
    logic [23:0] opnd;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    int          failures, n_compared;
    assign latch_data = opnd[6:0], low_byte_data = opnd[7:0], branch_offset = opnd[8:0];
    assign call_operand = opnd[10:0], vector_address = opnd[14:0], accumulator = opnd[23:16];
    pcs_core u_dut (.*);
    pcs_decoder_model u_dec (.*);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (stack_fault_reset) fault_seen <= 1'b1;
    initial begin
        #400000;
        failures++;
        end_sim;
    end
    // ============================================================
    // shared tasks
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task op(input logic [3:0] c, input logic [23:0] v);
        @(posedge clk);
        cmd <= c;
        opnd <= v;
        @(posedge clk);
        cmd <= 4'h0;
        #1;
    endtask
    // readies and answers are taken 1 ns after the edge, so the edge's own updates never race
    task axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic aw, w, ar, b;
        int n;
        @(posedge clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        n = 0;
        do begin
            #1;
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            ar = s_axi_arvalid & s_axi_arready;
            b = wr ? s_axi_bvalid : s_axi_rvalid;
            resp = wr ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (ar) s_axi_arvalid <= 1'b0;
            if (b) {s_axi_bready, s_axi_rready} <= 2'b00;
            n++;
        end while (!b && n < 40);
        if (!b) chk("axi answer", 1, 0);
    endtask
    // ============================================================
    // scenarios
    task t_reset;
        chk("pc after reset", 0, program_counter);
        axi(0, 8'h08, 0); chk("sp after reset", 32'h1F, q);
        axi(0, 8'h40, 0); chk("unmapped resp", 2, resp);
        axi(1, 8'h40, 0); chk("unmapped write resp", 2, resp);
    endtask
    task t_load;
        op(4'h9, 24'h55); op(4'h2, 24'hA3); chk("low write", 32'h55A3, program_counter);
        axi(0, 8'h00, 0); chk("low read", 32'hA3, q);
        axi(1, 8'h00, 32'h12); chk("write resp", 0, resp);
        axi(0, 8'h20, 0); chk("axi low write", 32'h5512, q);
        op(4'h1, 0); chk("advance", 32'h5513, program_counter);
    endtask
    task t_calls;
        op(4'h3, 24'h6AB); chk("call", 32'h56AB, program_counter);
        @(posedge clk) {cmd, opnd} <= {4'h4, 24'h3C0000};
        @(posedge clk) cmd <= 4'h8;
        @(posedge clk) cmd <= 4'h0;
        #1 chk("call then return", 32'h56AC, program_counter);
        op(4'h8, 0); chk("return", 32'h5514, program_counter);
        axi(0, 8'h08, 0); chk("sp empty again", 32'h1F, q);
        axi(0, 8'h04, 0); chk("latch kept", 32'h55, q);
    endtask
    task t_branch;
        op(4'h5, 24'hFF0000); chk("acc branch", 32'h5614, program_counter);
        op(4'h6, 24'h1F0); chk("back branch", 32'h5605, program_counter);
        op(4'h6, 24'h0FF); chk("fwd branch", 32'h5705, program_counter);
    endtask
    task t_stack;
        axi(1, 8'h18, 1);
        for (int k = 1; k <= 17; k++) op(4'h7, k * 16);
        axi(0, 8'h08, 0); chk("sp overflow", 32'h10, q);
        chk("irq overflow", 1, irq); chk("no fault reset", 0, fault_seen);
        axi(0, 8'h14, 0); chk("status ovf", 1, q); chk("irq cleared", 0, irq);
        axi(1, 8'h08, 0); axi(0, 8'h0C, 0); chk("entry0 low", 32'h01, q);
        axi(0, 8'h10, 0); chk("entry0 high", 32'h01, q);
        axi(1, 8'h0C, 32'h34); axi(1, 8'h10, 32'h12); op(4'h8, 0);
        chk("top write pop", 32'h1234, program_counter);
        axi(1, 8'h18, 2); op(4'h8, 0); chk("wrapped pop", 32'hF1, program_counter);
        chk("irq underflow", 1, irq); axi(0, 8'h14, 0); chk("status unf", 2, q);
        axi(0, 8'h08, 0); chk("sp underflow", 32'h0F, q);
    endtask
    task t_fault;
        axi(1, 8'h1C, 1); axi(1, 8'h08, 32'h0F); op(4'h7, 24'h100);
        repeat (2) @(posedge clk);
        chk("fault reset", 1, fault_seen);
        @(posedge clk) reset <= 1'b1;
        @(posedge clk) reset <= 1'b0;
        #1 chk("pc after reset", 0, program_counter);
    endtask
    initial begin
        {reset, cmd, opnd, fault_seen, s_axi_wstrb} = {1'b0, 4'h0, 24'h0, 1'b0, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        // a real rising edge on reset, so the async clear cannot miss time zero
        #1 reset = 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        #1;
        t_reset; t_load; t_calls; t_branch; t_stack; t_fault;
        end_sim;
    end
endmodule
`default_nettype wire
